// ### core/cptrc_pkg.sv
// Purpose: shared constants and types for the codec power, thermal and
//          power-on reset control block
// Assumes: 16-bit registers on a 32-bit classic wishbone bus
// Notes: register index times four gives the byte address
package cptrc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register indices (printed offsets are not all multiples of four)
    localparam logic [7:0] CPTRC_IDX_PWR_ONE = 8'h02;
    localparam logic [7:0] CPTRC_IDX_PWR_TWO = 8'h03;
    localparam logic [7:0] CPTRC_IDX_STATUS = 8'h11;
    localparam logic [7:0] CPTRC_IDX_OUT_CTRL = 8'h2A;
    localparam logic [7:0] CPTRC_IDX_SUPPLY = 8'h30;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CPTRC_B_INPUT_AMP = 12;
    localparam int CPTRC_B_RIGHT_ADC = 11;
    localparam int CPTRC_B_LEFT_ADC = 10;
    localparam int CPTRC_B_MIC_BIAS = 4;
    localparam int CPTRC_B_MASTER_BIAS = 3;
    localparam int CPTRC_B_LINE_OUT = 14;
    localparam int CPTRC_B_SPK_AMP = 12;
    localparam int CPTRC_B_NEG_SUPPLY = 11;
    localparam int CPTRC_B_POS_SUPPLY = 10;
    localparam int CPTRC_B_NEG_STAGE = 7;
    localparam int CPTRC_B_POS_STAGE = 6;
    localparam int CPTRC_B_SPK_MIXER = 2;
    localparam int CPTRC_B_PLAYBACK = 0;
    localparam int CPTRC_B_OVERHEAT = 15;
    localparam int CPTRC_B_THERM_SHDN = 15;

    ////////////////////////////////////////////////////////////////////////
    // writable masks and reset values
    localparam logic [15:0] CPTRC_PWR_ONE_MASK = 16'h1C18;
    localparam logic [15:0] CPTRC_PWR_TWO_MASK = 16'h5CC5;
    localparam logic [15:0] CPTRC_OUT_CTRL_MASK = 16'h8000;
    localparam logic [15:0] CPTRC_PWR_ONE_RST = 16'h0000;
    localparam logic [15:0] CPTRC_PWR_TWO_RST = 16'h0000;
    localparam logic [15:0] CPTRC_OUT_CTRL_RST = 16'h8000;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam real CPTRC_CLK_MHZ = 40.0;
    localparam real CPTRC_MIN_RESET_PERIOD_US = 10.6;
    localparam int CPTRC_MIN_RESET_CYCLES =
        int'($ceil(CPTRC_MIN_RESET_PERIOD_US * CPTRC_CLK_MHZ));
    localparam int CPTRC_POR_CW = 10;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0]
    {
        CPTRC_POR_OFF = 2'b00,
        CPTRC_POR_HOLD = 2'b01,
        CPTRC_POR_RUN = 2'b11
    } cptrc_por_state_t;

    typedef struct packed
    {
        logic regulator_supply_ok;
        logic core_supply_ok;
        logic interface_supply_ok;
        logic speaker_supply_ok;
    } cptrc_supply_t;

    typedef struct packed
    {
        logic input_amp_enable;
        logic right_adc_enable;
        logic left_adc_enable;
        logic mic_bias_enable;
        logic master_bias_enable;
        logic line_output_enable;
        logic speaker_amp_enable;
        logic speaker_mixer_enable;
        logic playback_converter_enable;
        logic speaker_neg_output;
        logic speaker_pos_output;
    } cptrc_enables_t;

endpackage

// ### core/cptrc_por.sv
// Purpose: power-on reset sequencer for one supply domain
// Assumes: supply good levels already synchronous to clk_i
// Notes: reset output is active low, held for the minimum period
`timescale 1ns/1ps
module cptrc_por
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_ok_i,
    output logic por_n_o
);
    import cptrc_pkg::*;

    cptrc_por_state_t state_ff;
    cptrc_por_state_t nxt_state;
    logic [CPTRC_POR_CW-1:0] cnt_ff;
    logic [CPTRC_POR_CW-1:0] nxt_cnt;
    logic por_n_ff;
    logic nxt_por_n;

    localparam logic [CPTRC_POR_CW-1:0] HOLD_LAST =
        CPTRC_POR_CW'(CPTRC_MIN_RESET_CYCLES - 1);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_por_n = 1'b0;
        case (state_ff)
            CPTRC_POR_OFF:
            begin
                nxt_cnt = '0;
                if (supply_ok_i)
                begin
                    nxt_state = CPTRC_POR_HOLD;
                end
            end
            CPTRC_POR_HOLD:
            begin
                // minimum hold even for an instant supply rise
                if (!supply_ok_i)
                begin
                    nxt_state = CPTRC_POR_OFF;
                end
                else if (cnt_ff == HOLD_LAST)
                begin
                    nxt_state = CPTRC_POR_RUN;
                    nxt_por_n = 1'b1;
                end
                else
                begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            CPTRC_POR_RUN:
            begin
                nxt_por_n = supply_ok_i;
                if (!supply_ok_i)
                begin
                    nxt_state = CPTRC_POR_OFF;
                end
            end
            default:
            begin
                nxt_state = CPTRC_POR_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_ff <= CPTRC_POR_OFF;
            cnt_ff <= '0;
            por_n_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            por_n_ff <= nxt_por_n;
        end
    end

    assign por_n_o = por_n_ff;

endmodule

// ### core/cptrc_spk_gate.sv
// Purpose: one speaker output gate
// Assumes: enables come from registers
// Notes: thermal disable does not touch the stored bits
`timescale 1ns/1ps
module cptrc_spk_gate
(
    input wire logic stage_enable_i,
    input wire logic supply_enable_i,
    input wire logic overheat_i,
    input wire logic thermal_shutdown_enable_i,
    output logic drive_o
);
    // both enables needed; overheat blocks only when shutdown enabled
    assign drive_o = stage_enable_i & supply_enable_i
        & ~(overheat_i & thermal_shutdown_enable_i);

endmodule

// ### core/cptrc_top.sv
// Purpose: codec power enables, thermal shutdown and power-on reset
// Assumes: classic wishbone slave, 32-bit data, supply levels synchronous
// Notes: byte address is register index times four; data in bits 15:0
`timescale 1ns/1ps

// What this block does
// RULE1 - first power register: five enables, reset 0
// RULE2 - software sets right ADC for right mic
// RULE3 - software sets left ADC for ADC/left mic
// RULE4 - second power register: eight enables, reset 0
// RULE5 - software sets DAC enable for DAC/beep
// RULE6 - speaker pin needs stage and supply enables
// RULE7 - software sets stage before supply enable
// RULE8 - software clears supply before stage enable
// RULE9 - read-only overheat status bit 15
// RULE10 - overheat available to poll, pin, events
// RULE11 - thermal shutdown enable disables speakers, reset 1
// RULE12 - reset asserted while regulator or core low
// RULE13 - during reset, hold defaults, drop writes
// RULE14 - release reset, defaults kept, writes accepted
// RULE15 - reset held at least 10.6 us
// RULE16 - reset asserts when either supply falls
// RULE17 - separate resets for interface and speaker domains
// RULE18 - software parks mode pin for low current
// RULE19 - software clears shutdown enable for low current
// RULE20 - thermal disable combinational, stored bits kept
module cptrc_top
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire cptrc_pkg::cptrc_supply_t supply_i,
    input wire logic overheat_i,
    output cptrc_pkg::cptrc_enables_t enables_o,
    output logic overheat_status_o,
    output logic overheat_event_o,
    output logic core_por_n_o,
    output logic interface_por_n_o,
    output logic speaker_por_n_o
);
    import cptrc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // power-on reset domains
    logic core_ok;
    logic core_por_n;
    logic if_por_n;
    logic spk_por_n;

    assign core_ok = supply_i.regulator_supply_ok
        & supply_i.core_supply_ok; // see RULE12 see RULE16

    cptrc_por u_core_por
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .supply_ok_i(core_ok),
        .por_n_o(core_por_n)
    ); // see RULE15

    cptrc_por u_if_por
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .supply_ok_i(supply_i.interface_supply_ok),
        .por_n_o(if_por_n)
    ); // see RULE17

    cptrc_por u_spk_por
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .supply_ok_i(supply_i.speaker_supply_ok),
        .por_n_o(spk_por_n)
    ); // see RULE17

    logic hold_rst;
    assign hold_rst = rst_i | ~core_por_n; // see RULE13

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0] pwr_one_ff;
    logic [15:0] nxt_pwr_one;
    logic [15:0] pwr_two_ff;
    logic [15:0] nxt_pwr_two;
    logic [15:0] out_ctrl_ff;
    logic [15:0] nxt_out_ctrl;
    logic overheat_ff;
    logic nxt_overheat;
    logic [31:0] dat_ff;
    logic [31:0] nxt_dat;
    logic ack_ff;
    logic nxt_ack;
    logic evt_ff;
    logic nxt_evt;
    logic [15:0] wmask;
    logic [15:0] rd_val;
    logic req;
    logic wr;

    assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
    // writes dropped while core reset holds
    assign wr = req & wb_we_i & core_por_n; // see RULE13 see RULE14
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb
    begin
        rd_val = 16'h0000;
        case (wb_adr_i)
            CPTRC_IDX_PWR_ONE: rd_val = pwr_one_ff;
            CPTRC_IDX_PWR_TWO: rd_val = pwr_two_ff;
            CPTRC_IDX_STATUS:
                rd_val = 16'(overheat_ff) << CPTRC_B_OVERHEAT; // see RULE9
            CPTRC_IDX_OUT_CTRL: rd_val = out_ctrl_ff;
            CPTRC_IDX_SUPPLY:
                rd_val = {13'h0000, spk_por_n, if_por_n, core_por_n};
            default: rd_val = 16'h0000;
        endcase
    end

    always_comb
    begin
        nxt_pwr_one = pwr_one_ff;
        nxt_pwr_two = pwr_two_ff;
        nxt_out_ctrl = out_ctrl_ff;
        nxt_ack = req;
        nxt_dat = 32'h00000000;
        nxt_overheat = overheat_i; // see RULE10
        nxt_evt = overheat_i ^ overheat_ff; // see RULE10
        if (req && !wb_we_i)
        begin
            nxt_dat = {16'h0000, rd_val};
        end
        if (wr)
        begin
            case (wb_adr_i)
                CPTRC_IDX_PWR_ONE:
                    nxt_pwr_one = (pwr_one_ff & ~wmask)
                        | (wb_dat_i[15:0] & wmask & CPTRC_PWR_ONE_MASK);
                CPTRC_IDX_PWR_TWO:
                    nxt_pwr_two = (pwr_two_ff & ~wmask)
                        | (wb_dat_i[15:0] & wmask & CPTRC_PWR_TWO_MASK);
                CPTRC_IDX_OUT_CTRL:
                    nxt_out_ctrl = (out_ctrl_ff & ~wmask)
                        | (wb_dat_i[15:0] & wmask & CPTRC_OUT_CTRL_MASK);
                default:
                begin
                    nxt_pwr_one = pwr_one_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (hold_rst)
        begin
            pwr_one_ff <= CPTRC_PWR_ONE_RST; // see RULE1
            pwr_two_ff <= CPTRC_PWR_TWO_RST; // see RULE4
            out_ctrl_ff <= CPTRC_OUT_CTRL_RST; // see RULE11
        end
        else
        begin
            pwr_one_ff <= nxt_pwr_one;
            pwr_two_ff <= nxt_pwr_two;
            out_ctrl_ff <= nxt_out_ctrl;
        end
    end

    // bus answers even during power-on reset, so software never hangs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
            overheat_ff <= 1'b0;
            evt_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
            overheat_ff <= nxt_overheat;
            evt_ff <= nxt_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // speaker gating and outputs
    logic [1:0] spk_drive;
    logic [1:0] spk_stage;
    logic [1:0] spk_supply;
    cptrc_enables_t en_ff;
    cptrc_enables_t nxt_en;

    assign spk_stage = {pwr_two_ff[CPTRC_B_NEG_STAGE],
                        pwr_two_ff[CPTRC_B_POS_STAGE]};
    assign spk_supply = {pwr_two_ff[CPTRC_B_NEG_SUPPLY],
                         pwr_two_ff[CPTRC_B_POS_SUPPLY]};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_spk
            cptrc_spk_gate u_gate
            (
                .stage_enable_i(spk_stage[gi]),
                .supply_enable_i(spk_supply[gi]),
                .overheat_i(overheat_ff),
                .thermal_shutdown_enable_i(
                    out_ctrl_ff[CPTRC_B_THERM_SHDN]),
                .drive_o(spk_drive[gi])
            ); // see RULE6 see RULE11 see RULE20
        end
    endgenerate

    always_comb
    begin
        nxt_en.input_amp_enable = pwr_one_ff[CPTRC_B_INPUT_AMP];
        nxt_en.right_adc_enable = pwr_one_ff[CPTRC_B_RIGHT_ADC];
        nxt_en.left_adc_enable = pwr_one_ff[CPTRC_B_LEFT_ADC];
        nxt_en.mic_bias_enable = pwr_one_ff[CPTRC_B_MIC_BIAS];
        nxt_en.master_bias_enable = pwr_one_ff[CPTRC_B_MASTER_BIAS];
        nxt_en.line_output_enable = pwr_two_ff[CPTRC_B_LINE_OUT];
        nxt_en.speaker_amp_enable = pwr_two_ff[CPTRC_B_SPK_AMP];
        nxt_en.speaker_mixer_enable = pwr_two_ff[CPTRC_B_SPK_MIXER];
        nxt_en.playback_converter_enable = pwr_two_ff[CPTRC_B_PLAYBACK];
        nxt_en.speaker_neg_output = spk_drive[1];
        nxt_en.speaker_pos_output = spk_drive[0];
    end

    logic cpor_ff;
    logic ipor_ff;
    logic spor_ff;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            en_ff <= '0;
            cpor_ff <= 1'b0;
            ipor_ff <= 1'b0;
            spor_ff <= 1'b0;
        end
        else
        begin
            en_ff <= nxt_en;
            cpor_ff <= core_por_n;
            ipor_ff <= if_por_n;
            spor_ff <= spk_por_n;
        end
    end

    assign enables_o = en_ff;
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign overheat_status_o = overheat_ff;
    assign overheat_event_o = evt_ff;
    assign core_por_n_o = cpor_ff;
    assign interface_por_n_o = ipor_ff;
    assign speaker_por_n_o = spor_ff;

endmodule

// ### tb/cptrc_top_sva.sv
// Purpose: port-level checks for cptrc_top
// Assumes: one clock, synchronous active-high reset
// Notes: shutdown bit shadowed from acked writes
`timescale 1ns/1ps
module cptrc_top_sva
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire cptrc_pkg::cptrc_supply_t supply_i,
    input wire logic overheat_i,
    input wire cptrc_pkg::cptrc_enables_t enables_o,
    input wire logic overheat_status_o,
    input wire logic overheat_event_o,
    input wire logic core_por_n_o
);
    import cptrc_pkg::*;
    logic core_ok;
    logic [9:0] ok_cnt_ff;
    logic [9:0] nxt_ok_cnt;
    logic shdn_ff;
    logic nxt_shdn;
    assign core_ok = supply_i.regulator_supply_ok & supply_i.core_supply_ok;
    always_comb
    begin
        nxt_ok_cnt = ok_cnt_ff;
        nxt_shdn = shdn_ff;
        if (rst_i || !core_ok)
            nxt_ok_cnt = 10'h000;
        else if (ok_cnt_ff != 10'h3FF)
            nxt_ok_cnt = ok_cnt_ff + 10'h001;
        if (rst_i || !core_por_n_o)
            nxt_shdn = 1'b1;
        else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[1]
            && wb_adr_i == CPTRC_IDX_OUT_CTRL)
            nxt_shdn = wb_dat_i[15];
    end
    always_ff @(posedge clk_i)
    begin
        ok_cnt_ff <= nxt_ok_cnt;
        shdn_ff <= nxt_shdn;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    property p_ack_once;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("request not acked next cycle");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_dat_upper;
        wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
    endproperty
    a_dat_upper: assert property (p_dat_upper)
        else $error("upper read data not zero");
    property p_status;
        !$past(rst_i) |-> overheat_status_o == $past(overheat_i);
    endproperty
    a_status: assert property (p_status)
        else $error("overheat status not following sensor");
    property p_event;
        $changed(overheat_status_o) |-> ##[0:1] overheat_event_o;
    endproperty
    a_event: assert property (p_event)
        else $error("no event on status change");
    property p_thermal;
        shdn_ff && overheat_status_o |=>
            !enables_o.speaker_neg_output && !enables_o.speaker_pos_output;
    endproperty
    a_thermal: assert property (p_thermal)
        else $error("speaker driven while overheated");
    property p_por_drop;
        !core_ok |-> ##[1:2] !core_por_n_o;
    endproperty
    a_por_drop: assert property (p_por_drop)
        else $error("core reset not asserted on supply loss");
    property p_por_min;
        $rose(core_por_n_o) |-> ok_cnt_ff >= CPTRC_MIN_RESET_CYCLES;
    endproperty
    a_por_min: assert property (p_por_min)
        else $error("core reset released too early");
    property p_hold_dflt;
        !core_por_n_o && !$past(core_por_n_o, 2) |-> enables_o == '0;
    endproperty
    a_hold_dflt: assert property (p_hold_dflt)
        else $error("enables set while core held in reset");
endmodule

bind cptrc_top cptrc_top_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .supply_i, .overheat_i, .enables_o, .overheat_status_o,
    .overheat_event_o, .core_por_n_o);

// ### tb/cptrc_top_tb.sv
// Purpose: register, thermal and reset sequences for cptrc_top
// Assumes: classic wishbone, ack one cycle after request
// Notes: por, enable and status outputs sampled on the falling edge to dodge update races; bus and event on the rising edge
`timescale 1ns/1ps
module cptrc_top_tb;
    import cptrc_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    cptrc_supply_t supply_i;
    cptrc_enables_t enables_o;
    logic overheat_i, overheat_status_o, overheat_event_o;
    logic core_por_n_o, interface_por_n_o, speaker_por_n_o;
    int num_errors = 0;
    int total_checks = 0;
    int ev_cnt = 0;
    logic [15:0] rd;
    logic [15:0] pd;
    logic pst, psu, nst, nsu;

    cptrc_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .supply_i,
        .overheat_i, .enables_o, .overheat_status_o, .overheat_event_o,
        .core_por_n_o, .interface_por_n_o, .speaker_por_n_o);

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        if (overheat_event_o === 1'b1)
            ev_cnt++;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
        input logic [15:0] d, input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {16'h0000, d};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rd = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0000, 4'hF);
        chk(rd, e);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic heat(input logic v);
        @(posedge clk_i);
        overheat_i <= v;
    endtask

    task automatic wait_por;
        while (core_por_n_o !== 1'b1)
            @(negedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(25 * 10000);
        num_errors++;
        test_done;
    end

    initial
    begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, overheat_i} = 4'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        supply_i = '0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wr(CPTRC_IDX_PWR_ONE, 16'hFFFF);
        rdchk(CPTRC_IDX_PWR_ONE, 16'h0000);
        rdchk(CPTRC_IDX_OUT_CTRL, 16'h8000);
        supply_i <= 4'hF;
        tick(424);
        chk(core_por_n_o, 1'b0);
        wait_por;
        chk({interface_por_n_o, speaker_por_n_o}, 2'b11);
        rdchk(CPTRC_IDX_SUPPLY, 16'h0007);
        rdchk(CPTRC_IDX_PWR_ONE, 16'h0000);
        rdchk(CPTRC_IDX_PWR_TWO, 16'h0000);
        rdchk(CPTRC_IDX_STATUS, 16'h0000);
        wr(CPTRC_IDX_PWR_ONE, 16'hFFFF);
        rdchk(CPTRC_IDX_PWR_ONE, 16'h1C18);
        wb(1'b1, CPTRC_IDX_PWR_TWO, 16'hFFFF, 4'h1);
        rdchk(CPTRC_IDX_PWR_TWO, 16'h00C5);
        wr(CPTRC_IDX_PWR_TWO, 16'hFFFF);
        rdchk(CPTRC_IDX_PWR_TWO, 16'h5CC5);
        wr(CPTRC_IDX_STATUS, 16'hFFFF);
        rdchk(CPTRC_IDX_STATUS, 16'h0000);
        wr(8'h05, 16'hFFFF);
        rdchk(8'h05, 16'h0000);
        tick(1);
        chk(enables_o, 11'h7FF);
        // per pin walk: both, stage, off, stage; stage leads supply
        for (int i = 0; i < 16; i++)
        begin
            pst = ~(i[1] & ~i[0]);
            psu = ~(i[1] | i[0]);
            nst = ~(i[3] & ~i[2]);
            nsu = ~(i[3] | i[2]);
            pd = {4'h0, nsu, psu, 2'b00, nst, pst, 6'h00};
            wr(CPTRC_IDX_PWR_TWO, pd);
            tick(2);
            chk(enables_o[1:0], {nst & nsu, pst & psu});
        end
        wr(CPTRC_IDX_PWR_TWO, 16'h0CC0);
        heat(1'b1);
        tick(3);
        chk({overheat_status_o, enables_o[1:0]}, 3'b100);
        rdchk(CPTRC_IDX_STATUS, 16'h8000);
        rdchk(CPTRC_IDX_PWR_TWO, 16'h0CC0);
        heat(1'b0);
        tick(3);
        chk(enables_o[1:0], 2'b11);
        wr(CPTRC_IDX_OUT_CTRL, 16'h0000);
        rdchk(CPTRC_IDX_OUT_CTRL, 16'h0000);
        heat(1'b1);
        tick(3);
        chk(enables_o[1:0], 2'b11);
        heat(1'b0);
        tick(3);
        chk(ev_cnt, 4);
        // drop core supply, then regulator supply
        for (int k = 0; k < 2; k++)
        begin
            wr(CPTRC_IDX_PWR_ONE, 16'h1C18);
            supply_i <= (k == 1) ? 4'b0111 : 4'b1011;
            tick(5);
            chk({core_por_n_o, interface_por_n_o, enables_o},
                13'h0800);
            wr(CPTRC_IDX_PWR_ONE, 16'h1C18);
            rdchk(CPTRC_IDX_PWR_ONE, 16'h0000);
            supply_i <= 4'hF;
            wait_por;
            rdchk(CPTRC_IDX_OUT_CTRL, 16'h8000);
        end
        supply_i <= 4'b1110;
        tick(3);
        chk({core_por_n_o, speaker_por_n_o}, 2'b10);
        rdchk(CPTRC_IDX_SUPPLY, 16'h0003);
        test_done;
    end
endmodule
